// [rtl/paaf_pkg.sv]
// Purpose: Shared constants and types for the port A alternate-function override block
// Assumes: Eight-pin port, 8-bit software register port
// Notes: Register offsets are word indices on the plain register port

package paaf_pkg;

  // ----------------------------------------
  // Geometry
  // ----------------------------------------
  localparam int NUM_PINS = 8;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [2:0] OFS_CHANGE_MASK = 3'h0;
  localparam logic [2:0] OFS_GROUP_CTRL = 3'h1;
  localparam logic [2:0] OFS_DIGITAL_OFF = 3'h2;
  localparam logic [2:0] OFS_PIN_LEVEL = 3'h3;
  localparam logic [2:0] OFS_INPUT_EN = 3'h4;

  // Field positions
  localparam int GROUP_EN_BIT = 0;

  // Reset values
  localparam logic [7:0] RST_CHANGE_MASK = 8'h00;
  localparam logic RST_GROUP_EN = 1'b0;
  localparam logic [7:0] RST_DIGITAL_OFF = 8'h00;
  localparam logic [7:0] RDATA_IDLE = 8'h00;

  // Analog comparator pins
  localparam int COMP_POS_PIN = 1;
  localparam int COMP_NEG_PIN = 2;

  // ----------------------------------------
  // Per-pin override bundle to the generic port-pin logic
  // ----------------------------------------
  typedef struct packed {
    logic pullup_override_enable;
    logic pullup_override_value;
    logic direction_override_enable;
    logic direction_override_value;
    logic out_value_override_enable;
    logic out_value_override_value;
    logic toggle_override_enable;
    logic input_buffer_override_enable;
    logic input_buffer_override_value;
  } paaf_ovr_t;

  localparam paaf_ovr_t OVR_IDLE = '0;

endpackage

// [rtl/paaf_pin_cell.sv]
// Purpose: Generic port-pin logic that applies override signals to one pin
// Assumes: Pad input already through its input conditioning
// Notes: Purely combinational; the pad level is clamped low when the input is off

`timescale 1ns/1ps

module paaf_pin_cell
  import paaf_pkg::*;
(
  // Overrides from the alternate function
  input wire paaf_ovr_t ovr,
  // Normal port register bits
  input wire logic dir_bit,
  input wire logic out_bit,
  input wire logic pullup_register_bit,
  input wire logic sleep_mode,
  // Pad
  input wire logic pad_in,
  output logic pad_out,
  output logic pad_oe,
  output logic pullup_en,
  // Digital input side
  output logic input_en,
  output logic pin_sense_tap
);

  // ----------------------------------------
  // Output path
  // ----------------------------------------
  wire logic port_bit;
  assign port_bit = out_bit ^ ovr.toggle_override_enable;
  assign pad_oe = ovr.direction_override_enable ? ovr.direction_override_value : dir_bit;
  assign pad_out = ovr.out_value_override_enable ? ovr.out_value_override_value : port_bit;

  assign pullup_en = ovr.pullup_override_enable ? ovr.pullup_override_value
                                                : (pullup_register_bit == 1'b1);

  // ----------------------------------------
  // Input path
  // ----------------------------------------
  // Override or sleep state
  assign input_en = ovr.input_buffer_override_enable ? ovr.input_buffer_override_value
                                                     : ~sleep_mode;

  assign pin_sense_tap = pad_in & input_en;

endmodule

// [rtl/paaf_port_a_override.sv]
// Purpose: Port A alternate-function override logic with its control registers
// Assumes: One clock, synchronous active-high reset, plain register port
// Notes: Override outputs are combinational from the control registers
//
// How it works
// - Pin n feeds pin-change source bit n of the first group.
// - Pin n reaches analog converter channel n over the analog pad path.
// - Pin 1 also drives the comparator positive input.
// - Pin 2 also drives the comparator negative input.
// - Input override enable is mask AND group enable OR digital-off bit.
// - Digital-off with pin-change disabled forces the input buffer off.
// - Pull-up, direction, value and toggle overrides are held at zero.
// - Input enable follows override value, else normal or sleep state.
// - Without override, pull-up is on exactly when its register bit is one.
// - Pin-change tap sits before the synchronizer; receiver syncs it.
//
// Local design decisions: the register offsets and the plain strobed port.

`timescale 1ns/1ps

module paaf_port_a_override
  import paaf_pkg::*;
#(
  parameter int PINS = NUM_PINS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // Normal port register bits and processor state
  input wire logic [PINS-1:0] port_dir_bits,
  input wire logic [PINS-1:0] port_out_bits,
  input wire logic [PINS-1:0] pullup_register_bit,
  input wire logic sleep_mode,
  // Pads
  input wire logic [PINS-1:0] pad_in,
  output logic [PINS-1:0] pad_out,
  output logic [PINS-1:0] pad_oe,
  output logic [PINS-1:0] pullup_en,
  // Alternate functions
  output logic [PINS-1:0] pin_sense_tap,
  output logic [PINS-1:0] pin_input_enable,
  output logic [PINS-1:0] analog_channel_input,
  output logic comparator_positive_in,
  output logic comparator_negative_in,
  output paaf_ovr_t [PINS-1:0] pin_override,
  output logic group_a_change_enable
);

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  logic [PINS-1:0] pin_change_source_bit_reg;
  logic [PINS-1:0] pin_change_source_bit_next;
  logic group_en_reg;
  logic group_en_next;
  logic [PINS-1:0] analog_digital_off_bit_reg;
  logic [PINS-1:0] analog_digital_off_bit_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic [PINS-1:0] pad_meta_reg;
  logic [PINS-1:0] pad_sync_reg;

  wire logic wr_mask;
  wire logic wr_ctrl;
  wire logic wr_off;
  assign wr_mask = reg_wr && (reg_addr == OFS_CHANGE_MASK);
  assign wr_ctrl = reg_wr && (reg_addr == OFS_GROUP_CTRL);
  assign wr_off = reg_wr && (reg_addr == OFS_DIGITAL_OFF);

  assign pin_change_source_bit_next = wr_mask ? reg_wdata[PINS-1:0] : pin_change_source_bit_reg;
  assign group_en_next = wr_ctrl ? reg_wdata[GROUP_EN_BIT] : group_en_reg;
  assign analog_digital_off_bit_next = wr_off ? reg_wdata[PINS-1:0] : analog_digital_off_bit_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      pin_change_source_bit_reg <= RST_CHANGE_MASK[PINS-1:0];
      group_en_reg <= RST_GROUP_EN;
      analog_digital_off_bit_reg <= RST_DIGITAL_OFF[PINS-1:0];
    end else begin
      pin_change_source_bit_reg <= pin_change_source_bit_next;
      group_en_reg <= group_en_next;
      analog_digital_off_bit_reg <= analog_digital_off_bit_next;
    end
  end

  assign group_a_change_enable = group_en_reg;

  // ----------------------------------------
  // Pad level synchronizer for software readback
  // ----------------------------------------
  // Status only; the pin-change tap must stay unsynchronized
  always_ff @(posedge clk) begin
    if (reset) begin
      pad_meta_reg <= '0;
      pad_sync_reg <= '0;
    end else begin
      pad_meta_reg <= pad_in;
      pad_sync_reg <= pad_meta_reg;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  wire logic [DATA_W-1:0] rd_sel;
  assign rd_sel =
      (reg_addr == OFS_CHANGE_MASK) ? DATA_W'(pin_change_source_bit_reg) :
      (reg_addr == OFS_GROUP_CTRL)  ? DATA_W'(group_en_reg) :
      (reg_addr == OFS_DIGITAL_OFF) ? DATA_W'(analog_digital_off_bit_reg) :
      (reg_addr == OFS_PIN_LEVEL)   ? DATA_W'(pad_sync_reg) :
      (reg_addr == OFS_INPUT_EN)    ? DATA_W'(pin_input_enable) : RDATA_IDLE;
  // Data stands only in the cycle after the strobe
  assign rdata_next = reg_rd ? rd_sel : RDATA_IDLE;

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_reg <= RDATA_IDLE;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  // ----------------------------------------
  // Override composition and pin cells
  // ----------------------------------------
  // Kept combinational so a register write takes effect at once
  wire logic [PINS-1:0] change_active;
  assign change_active = pin_change_source_bit_reg & {PINS{group_en_reg}};

  genvar gi;
  generate
    for (gi = 0; gi < PINS; gi++) begin : g_pin
      assign pin_override[gi].pullup_override_enable = 1'b0;
      assign pin_override[gi].pullup_override_value = 1'b0;
      assign pin_override[gi].direction_override_enable = 1'b0;
      assign pin_override[gi].direction_override_value = 1'b0;
      assign pin_override[gi].out_value_override_enable = 1'b0;
      assign pin_override[gi].out_value_override_value = 1'b0;
      assign pin_override[gi].toggle_override_enable = 1'b0;
      assign pin_override[gi].input_buffer_override_enable =
          change_active[gi] | analog_digital_off_bit_reg[gi];
      assign pin_override[gi].input_buffer_override_value = change_active[gi];

      paaf_pin_cell u_cell (
        .ovr(pin_override[gi]),
        .dir_bit(port_dir_bits[gi]),
        .out_bit(port_out_bits[gi]),
        .pullup_register_bit(pullup_register_bit[gi]),
        .sleep_mode(sleep_mode),
        .pad_in(pad_in[gi]),
        .pad_out(pad_out[gi]),
        .pad_oe(pad_oe[gi]),
        .pullup_en(pullup_en[gi]),
        .input_en(pin_input_enable[gi]),
        .pin_sense_tap(pin_sense_tap[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // Analog paths
  // ----------------------------------------
  // Direct pad to converter channel
  assign analog_channel_input = pad_in;
  assign comparator_positive_in = pad_in[COMP_POS_PIN];
  assign comparator_negative_in = pad_in[COMP_NEG_PIN];

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  wire logic [PINS-1:0] ie_oe_vec;
  wire logic [PINS-1:0] ie_ov_vec;
  wire logic [PINS-1:0] static_or_vec;
  generate
    for (gi = 0; gi < PINS; gi++) begin : g_vec
      assign ie_oe_vec[gi] = pin_override[gi].input_buffer_override_enable;
      assign ie_ov_vec[gi] = pin_override[gi].input_buffer_override_value;
      assign static_or_vec[gi] = pin_override[gi].pullup_override_enable |
          pin_override[gi].pullup_override_value |
          pin_override[gi].direction_override_enable |
          pin_override[gi].direction_override_value |
          pin_override[gi].out_value_override_enable |
          pin_override[gi].out_value_override_value |
          pin_override[gi].toggle_override_enable;
    end
  endgenerate

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  a_input_override_terms: assert property (
    ie_oe_vec == ((pin_change_source_bit_reg & {PINS{group_en_reg}}) |
                  analog_digital_off_bit_reg) &&
    ie_ov_vec == (pin_change_source_bit_reg & {PINS{group_en_reg}}))
    else $error("input override terms wrong");

  a_digital_off_forces: assert property (
    ((analog_digital_off_bit_reg & ~change_active) & pin_input_enable) == '0)
    else $error("digital-off pin left its input buffer on");

  a_static_overrides: assert property (
    static_or_vec == '0)
    else $error("static override not zero");

  a_change_tap_route: assert property (
    pin_sense_tap == (pad_in & pin_input_enable))
    else $error("pin-change tap not routed from pad");

  a_tap_unsynced: assert property (
    (pin_input_enable == '1 && $stable(pin_input_enable) && $changed(pad_in)) |->
      $changed(pin_sense_tap))
    else $error("pin-change tap delayed");

  a_analog_route: assert property (
    analog_channel_input == pad_in)
    else $error("analog channel not linked to pad");

  a_comparator_pins: assert property (
    comparator_positive_in == pad_in[1] && comparator_negative_in == pad_in[2])
    else $error("comparator inputs misrouted");

  a_input_enable_follow: assert property (
    pin_input_enable == ((ie_oe_vec & ie_ov_vec) | (~ie_oe_vec & {PINS{~sleep_mode}})))
    else $error("input enable does not follow override or sleep");

  a_pullup_follow: assert property (
    pullup_en == pullup_register_bit)
    else $error("pull-up not following its register bit");

  a_mask_write_now: assert property (
    (wr_mask && group_en_reg) |=> ie_ov_vec == $past(reg_wdata[PINS-1:0]))
    else $error("mask write not reflected next cycle");

  a_enable_write_now: assert property (
    wr_ctrl |=> group_a_change_enable == $past(reg_wdata[GROUP_EN_BIT]) &&
                ie_ov_vec == (pin_change_source_bit_reg & {PINS{$past(reg_wdata[0])}}))
    else $error("group enable write not reflected");

  a_read_one_cycle: assert property (
    (reg_rd && reg_addr == OFS_DIGITAL_OFF) |=>
      reg_rdata == DATA_W'(analog_digital_off_bit_reg) ##1
      ($past(reg_rd) || reg_rdata == 8'h00))
    else $error("read data timing wrong");

  c_change_enabled: cover property (group_en_reg && pin_change_source_bit_reg != '0);
  c_digital_off_only: cover property (analog_digital_off_bit_reg != '0 && !group_en_reg);
  c_sleep_override: cover property (sleep_mode && (ie_oe_vec & ie_ov_vec) != '0);
  c_back_to_back: cover property (reg_wr ##1 reg_rd ##1 reg_rd);

endmodule

// [test/paaf_far_side.sv]
// Purpose: Far-side model of the pin-change receiver and converter input mux
// Assumes: Same clock as the block; taps arrive unsynchronized
// Notes: Only change detection and channel pick, no interrupt flags

`timescale 1ns/1ps

module paaf_far_side (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // From the block
  input wire logic [7:0] pin_sense_tap,
  input wire logic [7:0] analog_channel_input,
  // Channel pick and results
  input wire logic [2:0] chan_sel,
  output logic change_flag,
  output logic chan_level
);
  logic [7:0] sync1_reg;
  logic [7:0] sync2_reg;
  logic [7:0] prev_reg;

  assign chan_level = analog_channel_input[chan_sel];
  assign change_flag = |(sync2_reg ^ prev_reg);

  always_ff @(posedge clk) begin
    if (reset) begin
      sync1_reg <= 8'h00;
      sync2_reg <= 8'h00;
      prev_reg <= 8'h00;
    end else begin
      sync1_reg <= pin_sense_tap;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end
endmodule

// [test/test_port_a_alt_function_override.sv]
// Purpose: Self-checking bench for the port A override block
// Assumes: 20 MHz clock, synchronous reset held 12 cycles
// Notes: Reset-value reads first, then table rows, then register and receiver cases

`timescale 1ns/1ps

module test_port_a_alt_function_override
  import paaf_pkg::*;
();
  typedef struct packed {
    logic [7:0] m;
    logic e;
    logic [7:0] o;
    logic s;
    logic [7:0] p;
    logic [7:0] oe;
    logic [7:0] ie;
  } paaf_row_t;

  paaf_row_t rows [6] = '{
    '{8'h05, 1'b1, 8'h00, 1'b0, 8'hff, 8'h05, 8'hff},
    '{8'h05, 1'b0, 8'h00, 1'b1, 8'hff, 8'h00, 8'h00},
    '{8'h0f, 1'b1, 8'hf0, 1'b1, 8'haa, 8'hff, 8'h0f},
    '{8'h00, 1'b1, 8'h3c, 1'b0, 8'h55, 8'h3c, 8'hc3},
    '{8'hf0, 1'b1, 8'hf0, 1'b0, 8'h0f, 8'hf0, 8'hff},
    '{8'hff, 1'b0, 8'h81, 1'b0, 8'h81, 8'h81, 8'h7e}};

  logic clk;
  logic reset = 1'b1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic [DATA_W-1:0] reg_rdata;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] dir = 8'h00;
  logic [7:0] outb = 8'h00;
  logic [7:0] pub = 8'h00;
  logic [7:0] pad = 8'h00;
  logic slp = 1'b0;
  logic [7:0] pad_out, pad_oe, pullup_en, tap, ie, ach;
  logic cp, cn, gen, chg, lvl, seen;
  paaf_ovr_t [7:0] ovr;
  logic [2:0] sel = 3'h4;
  logic rd_v = 1'b0;
  logic [7:0] rd_e = 8'h00;
  logic [7:0] exp_n = 8'h00;
  int miscompares = 0;
  int num_checks = 0;
  int n;

  paaf_port_a_override dut (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port_dir_bits(dir), .port_out_bits(outb),
    .pullup_register_bit(pub), .sleep_mode(slp), .pad_in(pad), .pad_out(pad_out),
    .pad_oe(pad_oe), .pullup_en(pullup_en), .pin_sense_tap(tap), .pin_input_enable(ie),
    .analog_channel_input(ach), .comparator_positive_in(cp), .comparator_negative_in(cn),
    .pin_override(ovr), .group_a_change_enable(gen));

  paaf_far_side far (
    .clk(clk), .reset(reset), .pin_sense_tap(tap), .analog_channel_input(ach),
    .chan_sel(sel), .change_flag(chg), .chan_level(lvl));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Strobes stay up until the next task or idle, so no signal moves twice per step
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    reg_addr <= a;
    exp_n <= e;
    @(posedge clk);
  endtask

  task automatic idle;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask

  // Read data stand only in the cycle after the strobe, zero otherwise
  always @(posedge clk) begin
    rd_v <= reg_rd;
    rd_e <= exp_n;
    if (!reset) check("rdata", {8'h00, reg_rdata}, {8'h00, rd_v ? rd_e : 8'h00});
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rd(OFS_CHANGE_MASK, RST_CHANGE_MASK);
    rd(OFS_GROUP_CTRL, {7'h00, RST_GROUP_EN});
    rd(OFS_DIGITAL_OFF, RST_DIGITAL_OFF);
    rd(3'h5, 8'h00);
    idle;
    for (int r = 0; r < 6; r++) begin
      wr(OFS_CHANGE_MASK, rows[r].m);
      wr(OFS_GROUP_CTRL, {7'h7f, rows[r].e});
      wr(OFS_DIGITAL_OFF, rows[r].o);
      pad <= rows[r].p;
      slp <= rows[r].s;
      outb <= rows[r].p ^ 8'h3c;
      dir <= ~rows[r].p & 8'hf9;
      pub <= rows[r].m & 8'hf9;
      rd(OFS_GROUP_CTRL, {7'h00, rows[r].e});
      rd(OFS_INPUT_EN, rows[r].ie);
      idle;
      @(negedge clk);
      for (int i = 0; i < 8; i++) begin
        check("override", {7'h00, ovr[i]}, {14'h0000, rows[r].oe[i], rows[r].m[i] & rows[r].e});
      end
      check("inen_analog", {ie, ach}, {rows[r].ie, rows[r].p});
      check("tap_pullup", {tap, pullup_en}, {rows[r].p & rows[r].ie, pub});
      check("pads", {pad_out, pad_oe}, {outb, dir});
      check("comp_group", {13'h0000, cp, cn, gen}, {13'h0000, rows[r].p[1], rows[r].p[2], rows[r].e});
      @(posedge clk);
    end
    wr(OFS_GROUP_CTRL, 8'h01);
    reg_wr <= 1'b0;
    @(negedge clk);
    check("same_cycle", {7'h00, ovr[3]}, 16'h0003);
    @(posedge clk);
    wr(OFS_INPUT_EN, 8'h00);
    rd(OFS_INPUT_EN, 8'hff);
    rd(OFS_PIN_LEVEL, 8'h81);
    rd(OFS_DIGITAL_OFF, 8'h81);
    rd(OFS_CHANGE_MASK, 8'hff);
    rd(3'h7, 8'h00);
    idle;
    pad <= 8'h91;
    seen = 1'b0;
    for (n = 0; n < 6 && !seen; n++) begin
      @(negedge clk);
      seen = chg;
    end
    check("change_seen", {15'h0000, seen}, 16'h0001);
    check("chan_level", {15'h0000, lvl}, 16'h0001);
    @(posedge clk);
    wr(OFS_CHANGE_MASK, 8'hef);
    wr(OFS_DIGITAL_OFF, 8'h10);
    idle;
    repeat (4) @(posedge clk);
    pad <= 8'h81;
    seen = 1'b0;
    repeat (6) begin
      @(negedge clk);
      seen = seen | chg;
    end
    check("change_off", {7'h00, seen, ie}, 16'h00ef);
    // Mid-run reset must clear the override registers again
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rd(OFS_DIGITAL_OFF, RST_DIGITAL_OFF);
    idle;
    @(negedge clk);
    check("after_reset", {7'h00, gen, ie}, {7'h00, RST_GROUP_EN, 8'hff});
    give_verdict;
  end
endmodule
